// file: dtc_core.sv
// Dual 16-bit timer/counter core with mode and run/flag registers.
// Assumes single-cycle register writes and reads from the processor core.
//
// Contract
// - Timer mode counts once per machine cycle.
// - Counter mode counts sampled high-to-low transitions.
// - Edge count lands in following machine cycle.
// - Edge recognition spans two machine cycles.
// - Gate set: count while pin high, run.
// - Gate clear: count whenever run set.
// - Counter select picks pin or machine cycles.
// - Mode 00: high half with 5-bit prescaler.
// - Mode 01: cascaded 16-bit counter.
// - Mode 10: low half auto-reloads from high.
// - Mode 11 stops timer one.
// - Mode 11 splits timer zero halves.
// - Mode register nibbles: gate, select, mode.
// - Control upper bits flags/run; lower unused.
// - Mode and control registers reset zero.
// - Each timer has two accessible halves.
// - Shared pins pass only when latch one.
// - Overflow sets flag; vectoring clears it.
// - Run bit starts/stops without clearing counters.
// - 13-bit mode ignores low half top bits.
`timescale 1ns/10ps
`default_nettype none
module dtc_core
    import dtc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr_en,
    input  wire logic [7:0] sfr_wr_data,
    input  wire logic       sfr_rd_en,
    output logic [7:0]      sfr_rd_data,
    output logic            sfr_rd_hit,
    input  wire logic       irq_vector_zero,
    input  wire logic       irq_vector_one,
    input  wire logic [7:0] port3_latch,
    input  wire logic       count_pin_zero,
    input  wire logic       count_pin_one,
    input  wire logic       gate_irq_pin_zero,
    input  wire logic       gate_irq_pin_one,
    output logic            overflow_flag_zero,
    output logic            overflow_flag_one
);

    logic [7:0]  timer_run_and_flag_control_q;
    logic [7:0]  timer_run_and_flag_control_d;
    logic [7:0]  timer_mode_select_q;
    logic [7:0]  low0_q;
    logic [7:0]  high0_q;
    logic [7:0]  low1_q;
    logic [7:0]  high1_q;
    logic [7:0]  low0_d;
    logic [7:0]  high0_d;
    logic [7:0]  low1_d;
    logic [7:0]  high1_d;

    // Advance one timer by one count in the given mode: {overflow, high, low}
    function automatic logic [16:0] dtc_step(input logic [1:0] mode,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi,
                                             input logic       inc);
        logic [16:0] r;
        logic [5:0]  pre;
        logic [8:0]  top;
        r   = {1'b0, hi, lo};
        pre = 6'h00;
        top = 9'h000;
        if (inc) begin
            case (mode)
                MODE_13BIT: begin
                    pre = {1'b0, lo[4:0]} + 6'h01;
                    if (pre[5]) begin
                        top = {1'b0, hi} + 9'h001;
                        r   = {top[8], top[7:0], lo[7:5], 5'h00};
                    end else begin
                        r = {1'b0, hi, lo[7:5], pre[4:0]};
                    end
                end
                MODE_16BIT: begin
                    r = {1'b0, hi, lo} + 17'h00001;
                end
                MODE_RELOAD: begin
                    if (lo == 8'hff) begin
                        r = {1'b1, hi, hi};
                    end else begin
                        r = {1'b0, hi, lo + 8'h01};
                    end
                end
                default: begin
                    r = {(lo == 8'hff), hi, lo + 8'h01};
                end
            endcase
        end
        return r;
    endfunction

    // Register decode
    logic wr_ctl;
    logic wr_mode;
    logic wr_low0;
    logic wr_low1;
    logic wr_high0;
    logic wr_high1;
    assign wr_ctl   = sfr_wr_en && (sfr_addr == SFR_RUN_FLAG_CTL_ADDR);
    assign wr_mode  = sfr_wr_en && (sfr_addr == SFR_MODE_SEL_ADDR);
    assign wr_low0  = sfr_wr_en && (sfr_addr == SFR_LOW_ZERO_ADDR);
    assign wr_low1  = sfr_wr_en && (sfr_addr == SFR_LOW_ONE_ADDR);
    assign wr_high0 = sfr_wr_en && (sfr_addr == SFR_HIGH_ZERO_ADDR);
    assign wr_high1 = sfr_wr_en && (sfr_addr == SFR_HIGH_ONE_ADDR);

    // Mode fields
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic       gate0;
    logic       gate1;
    logic       csel0;
    logic       csel1;
    logic       run0;
    logic       run1;
    assign mode0 = timer_mode_select_q[MODE0_SEL_LSB +: 2];
    assign mode1 = timer_mode_select_q[MODE1_SEL_LSB +: 2];
    assign gate0 = timer_mode_select_q[MODE0_GATE_BIT];
    assign gate1 = timer_mode_select_q[MODE1_GATE_BIT];
    assign csel0 = timer_mode_select_q[MODE0_CT_BIT];
    assign csel1 = timer_mode_select_q[MODE1_CT_BIT];
    assign run0  = timer_run_and_flag_control_q[RUN_ZERO_BIT];
    assign run1  = timer_run_and_flag_control_q[RUN_ONE_BIT];

    // Shared pins reach the timers only through a latch holding one
    logic pin_cnt0;
    logic pin_cnt1;
    logic pin_gate0;
    logic pin_gate1;
    assign pin_cnt0  = count_pin_zero & port3_latch[LATCH_COUNT_ZERO_BIT];
    assign pin_cnt1  = count_pin_one & port3_latch[LATCH_COUNT_ONE_BIT];
    assign pin_gate0 = gate_irq_pin_zero & port3_latch[LATCH_GATE_ZERO_BIT];
    assign pin_gate1 = gate_irq_pin_one & port3_latch[LATCH_GATE_ONE_BIT];

    logic       update_stb;
    logic [1:0] fall_seen;

    dtc_mcycle u_mcycle (
        .clk        (clk),
        .reset      (reset),
        .count_pins ({pin_cnt1, pin_cnt0}),
        .update_stb (update_stb),
        .sample_stb (),
        .fall_seen  (fall_seen)
    );

    // Count enables
    logic enable0;
    logic enable1;
    logic src0;
    logic src1;
    logic inc0;
    logic inc1;
    logic split0;
    logic inc_high0_split;
    assign enable0 = run0 && (!gate0 || pin_gate0);
    assign enable1 = run1 && (!gate1 || pin_gate1);
    assign src0    = csel0 ? fall_seen[0] : 1'b1;
    assign src1    = csel1 ? fall_seen[1] : 1'b1;
    assign split0  = (mode0 == MODE_SPLIT);
    assign inc0    = update_stb && enable0 && src0;
    assign inc1    = update_stb && enable1 && src1 && (mode1 != MODE_SPLIT);
    // Split high half: machine cycles only, under timer one's run bit
    assign inc_high0_split = split0 && update_stb && run1;

    logic [16:0] step0;
    logic [16:0] step1;
    logic [8:0]  high0_split;
    logic        ovf0;
    logic        ovf1;
    assign step0       = dtc_step(mode0, low0_q, high0_q, inc0);
    assign step1       = dtc_step(mode1, low1_q, high1_q, inc1);
    assign high0_split = {1'b0, high0_q} + {8'h00, inc_high0_split};
    assign ovf0        = step0[16];
    // Timer one loses its flag while timer zero is split
    assign ovf1        = split0 ? high0_split[8] : step1[16];

    // Software writes win over counting in the same cycle
    assign low0_d  = wr_low0 ? sfr_wr_data : step0[7:0];
    assign high0_d = wr_high0 ? sfr_wr_data : (split0 ? high0_split[7:0] : step0[15:8]);
    assign low1_d  = wr_low1 ? sfr_wr_data : step1[7:0];
    assign high1_d = wr_high1 ? sfr_wr_data : step1[15:8];

    // Flag set beats both software clear and vector clear
    logic [7:0] ctl_base;
    assign ctl_base = wr_ctl ? sfr_wr_data : timer_run_and_flag_control_q;
    always_comb begin
        timer_run_and_flag_control_d = ctl_base;
        timer_run_and_flag_control_d[OVF_ZERO_BIT] =
            ovf0 | (ctl_base[OVF_ZERO_BIT] & ~irq_vector_zero);
        timer_run_and_flag_control_d[OVF_ONE_BIT] =
            ovf1 | (ctl_base[OVF_ONE_BIT] & ~irq_vector_one);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            timer_run_and_flag_control_q <= RUN_FLAG_CTL_RESET;
            timer_mode_select_q          <= MODE_SEL_RESET;
        end else begin
            timer_run_and_flag_control_q <= timer_run_and_flag_control_d;
            timer_mode_select_q          <= wr_mode ? sfr_wr_data : timer_mode_select_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            low0_q  <= COUNTER_RESET;
            high0_q <= COUNTER_RESET;
            low1_q  <= COUNTER_RESET;
            high1_q <= COUNTER_RESET;
        end else begin
            low0_q  <= low0_d;
            high0_q <= high0_d;
            low1_q  <= low1_d;
            high1_q <= high1_d;
        end
    end

    // Read path; unmapped addresses answer zero with no hit
    logic [7:0] rd_mux;
    logic       rd_known;
    assign rd_known = (sfr_addr == SFR_RUN_FLAG_CTL_ADDR) || (sfr_addr == SFR_MODE_SEL_ADDR)
                   || (sfr_addr == SFR_LOW_ZERO_ADDR) || (sfr_addr == SFR_LOW_ONE_ADDR)
                   || (sfr_addr == SFR_HIGH_ZERO_ADDR) || (sfr_addr == SFR_HIGH_ONE_ADDR);
    assign rd_mux = (sfr_addr == SFR_RUN_FLAG_CTL_ADDR) ? timer_run_and_flag_control_q :
                    (sfr_addr == SFR_MODE_SEL_ADDR)     ? timer_mode_select_q :
                    (sfr_addr == SFR_LOW_ZERO_ADDR)     ? low0_q :
                    (sfr_addr == SFR_LOW_ONE_ADDR)      ? low1_q :
                    (sfr_addr == SFR_HIGH_ZERO_ADDR)    ? high0_q :
                    (sfr_addr == SFR_HIGH_ONE_ADDR)     ? high1_q : 8'h00;

    always_ff @(posedge clk) begin
        if (reset) begin
            sfr_rd_data <= 8'h00;
            sfr_rd_hit  <= 1'b0;
        end else begin
            sfr_rd_data <= (sfr_rd_en && rd_known) ? rd_mux : 8'h00;
            sfr_rd_hit  <= sfr_rd_en && rd_known;
        end
    end

    assign overflow_flag_zero = timer_run_and_flag_control_q[OVF_ZERO_BIT];
    assign overflow_flag_one  = timer_run_and_flag_control_q[OVF_ONE_BIT];

    // Checks
    sequence s_quiet0;
        !wr_low0 && !wr_high0 && !wr_mode && !wr_ctl;
    endsequence

    sequence s_quiet1;
        !wr_low1 && !wr_high1 && !wr_mode && !wr_ctl;
    endsequence

    AST_RESET_ZERO: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> (timer_mode_select_q == 8'h00)
                      && (timer_run_and_flag_control_q == 8'h00))
        else $error("control registers not zero after reset");

    AST_TIMER_TICK: assert property (@(posedge clk) disable iff (reset)
        (update_stb && run0 && !gate0 && !csel0 && mode0 == MODE_16BIT) and s_quiet0
        |=> {high0_q, low0_q} == {$past(high0_q), $past(low0_q)} + 16'h0001)
        else $error("timer did not tick on machine cycle");

    AST_RUN_OFF_HOLDS: assert property (@(posedge clk) disable iff (reset)
        !run0 and s_quiet0 |=> $stable(low0_q))
        else $error("low half moved while stopped");

    AST_GATE_LOW_HOLDS: assert property (@(posedge clk) disable iff (reset)
        (gate0 && !pin_gate0) and s_quiet0 |=> $stable(low0_q))
        else $error("gated timer counted with pin low");

    AST_NO_EDGE_HOLDS: assert property (@(posedge clk) disable iff (reset)
        (csel1 && !fall_seen[1] && mode1 != MODE_SPLIT) and s_quiet1
        |=> $stable(low1_q))
        else $error("counter moved without an edge");

    AST_RELOAD: assert property (@(posedge clk) disable iff (reset)
        (inc0 && mode0 == MODE_RELOAD && low0_q == 8'hff) and s_quiet0
        |=> low0_q == $past(high0_q) && overflow_flag_zero)
        else $error("auto reload failed");

    AST_PRESCALE: assert property (@(posedge clk) disable iff (reset)
        (inc0 && mode0 == MODE_13BIT && low0_q[4:0] == 5'h1f) and s_quiet0
        |=> high0_q == $past(high0_q) + 8'h01 && low0_q[4:0] == 5'h00)
        else $error("prescaler carry lost");

    AST_ONE_STOPPED: assert property (@(posedge clk) disable iff (reset)
        (mode1 == MODE_SPLIT) and s_quiet1 |=> $stable({high1_q, low1_q}))
        else $error("timer one counted while stopped");

    AST_FLAG_SET_WINS: assert property (@(posedge clk) disable iff (reset)
        ovf0 |=> overflow_flag_zero ##1 (overflow_flag_zero || irq_vector_zero
                                         || $past(wr_ctl) || $past(irq_vector_zero)))
        else $error("overflow flag not raised");

endmodule
`default_nettype wire

// file: dtc_mcycle.sv
// Machine-cycle strobes and count-pin falling-edge detection.
// Assumes count pins already gated by their port latch bits.
`timescale 1ns/10ps
`default_nettype none
module dtc_mcycle
    import dtc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [1:0] count_pins,
    output logic            update_stb,
    output logic            sample_stb,
    output logic [1:0]      fall_seen
);

    logic [3:0] phase_q;
    logic [3:0] phase_d;
    logic [1:0] smp_q;
    logic       wrap;

    assign wrap    = (phase_q == MCYCLE_LAST);
    assign phase_d = wrap ? 4'h0 : phase_q + 4'h1;

    always_ff @(posedge clk) begin
        if (reset) begin
            phase_q <= 4'h0;
        end else begin
            phase_q <= phase_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            update_stb <= 1'b0;
            sample_stb <= 1'b0;
        end else begin
            update_stb <= (phase_d == UPDATE_PHASE);
            sample_stb <= (phase_d == SAMPLE_PHASE);
        end
    end

    // Edge held until next sample, so each edge is consumed by one update
    always_ff @(posedge clk) begin
        if (reset) begin
            smp_q     <= 2'h0;
            fall_seen <= 2'h0;
        end else if (sample_stb) begin
            smp_q     <= count_pins;
            fall_seen <= smp_q & ~count_pins;
        end
    end

    AST_STROBE_PERIOD: assert property (@(posedge clk) disable iff (reset)
        update_stb |-> ##12 update_stb)
        else $error("machine cycle strobe not periodic");

    AST_STROBE_GAP: assert property (@(posedge clk) disable iff (reset)
        update_stb |=> !update_stb [*8])
        else $error("machine cycle strobe too frequent");

endmodule
`default_nettype wire

// file: dtc_pin_src.sv
// Count-pin source standing in for the external pulse driver.
// Assumes the port 3 pull-up: the line rests high outside bursts.
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_src
    import dtc_pkg::*;
#(
    parameter int HOLD = MCYCLE_CLKS
)
(
    input  wire logic clk,
    output logic      pin
);
    // Pulled-up idle level
    initial begin
        pin = 1'b1;
    end

    // Each level held exactly one machine cycle, the tightest legal case
    task automatic burst(input int n);
        @(posedge clk);
        #1;
        for (int i = 0; i < n; i++) begin
            pin = 1'b0;
            repeat (HOLD) @(posedge clk);
            #1 pin = 1'b1;
            repeat (HOLD) @(posedge clk);
            #1;
        end
    endtask
endmodule
`default_nettype wire

// file: dtc_pkg.sv
// Shared constants of the dual timer/counter core.
// Assumes an 8-bit special-function register port from the processor core.
`default_nettype none
package dtc_pkg;

    // Register addresses
    localparam logic [7:0] SFR_RUN_FLAG_CTL_ADDR = 8'h88;
    localparam logic [7:0] SFR_MODE_SEL_ADDR     = 8'h89;
    localparam logic [7:0] SFR_LOW_ZERO_ADDR     = 8'h8a;
    localparam logic [7:0] SFR_LOW_ONE_ADDR      = 8'h8b;
    localparam logic [7:0] SFR_HIGH_ZERO_ADDR    = 8'h8c;
    localparam logic [7:0] SFR_HIGH_ONE_ADDR     = 8'h8d;

    // Reset values
    localparam logic [7:0] RUN_FLAG_CTL_RESET = 8'h00;
    localparam logic [7:0] MODE_SEL_RESET     = 8'h00;
    localparam logic [7:0] COUNTER_RESET      = 8'h00;

    // Mode register fields
    localparam int MODE1_GATE_BIT = 7;
    localparam int MODE1_CT_BIT   = 6;
    localparam int MODE1_SEL_LSB  = 4;
    localparam int MODE0_GATE_BIT = 3;
    localparam int MODE0_CT_BIT   = 2;
    localparam int MODE0_SEL_LSB  = 0;

    // Control register fields
    localparam int OVF_ONE_BIT  = 7;
    localparam int RUN_ONE_BIT  = 6;
    localparam int OVF_ZERO_BIT = 5;
    localparam int RUN_ZERO_BIT = 4;

    // Port latch positions of the shared pins
    localparam int LATCH_GATE_ZERO_BIT  = 2;
    localparam int LATCH_GATE_ONE_BIT   = 3;
    localparam int LATCH_COUNT_ZERO_BIT = 4;
    localparam int LATCH_COUNT_ONE_BIT  = 5;

    // Mode encodings
    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;

    // Machine cycle timing, in core clocks
    localparam int         MCYCLE_CLKS  = 12;
    localparam logic [3:0] MCYCLE_LAST  = 4'(MCYCLE_CLKS - 1);
    localparam logic [3:0] UPDATE_PHASE = 4'h4;
    localparam logic [3:0] SAMPLE_PHASE = 4'h9;

endpackage
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the dual timer/counter core.
// Assumes the register port and pin sources of dtc_pin_src.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import dtc_pkg::*;
;
    logic       clk;
    logic       reset;
    logic [7:0] sfr_addr;
    logic       sfr_wr_en;
    logic [7:0] sfr_wr_data;
    logic       sfr_rd_en;
    logic [7:0] sfr_rd_data;
    logic       sfr_rd_hit;
    logic       irq_vector_zero;
    logic       irq_vector_one;
    logic [7:0] port3_latch;
    logic       count_pin_zero;
    logic       count_pin_one;
    logic       gate_irq_pin_zero;
    logic       gate_irq_pin_one;
    logic       overflow_flag_zero;
    logic       overflow_flag_one;
    int         fails;
    int         total_checks;

    dtc_core i_dut (
        .clk                (clk),
        .reset              (reset),
        .sfr_addr           (sfr_addr),
        .sfr_wr_en          (sfr_wr_en),
        .sfr_wr_data        (sfr_wr_data),
        .sfr_rd_en          (sfr_rd_en),
        .sfr_rd_data        (sfr_rd_data),
        .sfr_rd_hit         (sfr_rd_hit),
        .irq_vector_zero    (irq_vector_zero),
        .irq_vector_one     (irq_vector_one),
        .port3_latch        (port3_latch),
        .count_pin_zero     (count_pin_zero),
        .count_pin_one      (count_pin_one),
        .gate_irq_pin_zero  (gate_irq_pin_zero),
        .gate_irq_pin_one   (gate_irq_pin_one),
        .overflow_flag_zero (overflow_flag_zero),
        .overflow_flag_one  (overflow_flag_one)
    );
    dtc_pin_src i_src_zero (.clk(clk), .pin(count_pin_zero));
    dtc_pin_src i_src_one (.clk(clk), .pin(count_pin_one));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 sfr_wr_en = 1'b1;
        sfr_addr = a;
        sfr_wr_data = d;
        @(posedge clk);
        #1 sfr_wr_en = 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic hit_exp;
        hit_exp = (a >= SFR_RUN_FLAG_CTL_ADDR) && (a <= SFR_HIGH_ONE_ADDR);
        @(posedge clk);
        #1 sfr_rd_en = 1'b1;
        sfr_addr = a;
        @(posedge clk);
        #1 sfr_rd_en = 1'b0;
        chk(name, exp, sfr_rd_data);
        chk({name, " hit"}, {7'h00, hit_exp}, {7'h00, sfr_rd_hit});
    endtask

    // Window of exactly n machine cycles holds exactly n update strobes
    // Flags taken in the stop cycle itself, so a late overflow is kept
    task automatic run_for(input logic [7:0] ctl, input int n);
        wr(SFR_RUN_FLAG_CTL_ADDR, ctl);
        repeat (MCYCLE_CLKS * n - 1) @(posedge clk);
        #1 sfr_wr_en = 1'b1;
        sfr_addr = SFR_RUN_FLAG_CTL_ADDR;
        sfr_wr_data = {overflow_flag_one, 1'b0, overflow_flag_zero, 1'b0, ctl[3:0]};
        @(posedge clk);
        #1 sfr_wr_en = 1'b0;
    endtask

    task automatic vec(input logic v0, input logic v1);
        @(posedge clk);
        #1 irq_vector_zero = v0;
        irq_vector_one = v1;
        @(posedge clk);
        #1 irq_vector_zero = 1'b0;
        irq_vector_one = 1'b0;
    endtask

    task automatic load(input logic [7:0] m, input logic [7:0] l0, input logic [7:0] h0,
                        input logic [7:0] l1, input logic [7:0] h1);
        wr(SFR_MODE_SEL_ADDR, m);
        wr(SFR_LOW_ZERO_ADDR, l0);
        wr(SFR_HIGH_ZERO_ADDR, h0);
        wr(SFR_LOW_ONE_ADDR, l1);
        wr(SFR_HIGH_ONE_ADDR, h1);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial begin
        fails = 0;
        total_checks = 0;
        reset = 1'b1;
        sfr_addr = 8'h00;
        sfr_wr_en = 1'b0;
        sfr_wr_data = 8'h00;
        sfr_rd_en = 1'b0;
        irq_vector_zero = 1'b0;
        irq_vector_one = 1'b0;
        port3_latch = 8'hff;
        gate_irq_pin_zero = 1'b1;
        gate_irq_pin_one = 1'b1;
        repeat (16) @(posedge clk);
        #1 reset = 1'b0;
        rdchk("ctl reset", SFR_RUN_FLAG_CTL_ADDR, RUN_FLAG_CTL_RESET);
        rdchk("mode reset", SFR_MODE_SEL_ADDR, MODE_SEL_RESET);
        rdchk("unmapped", 8'h80, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rdchk("half reset", SFR_LOW_ZERO_ADDR + 8'(i), COUNTER_RESET);
            wr(SFR_LOW_ZERO_ADDR + 8'(i), 8'h11 * 8'(i + 1));
        end
        for (int i = 0; i < 4; i++)
            rdchk("half", SFR_LOW_ZERO_ADDR + 8'(i), 8'h11 * 8'(i + 1));
        wr(SFR_MODE_SEL_ADDR, 8'ha5);
        rdchk("mode", SFR_MODE_SEL_ADDR, 8'ha5);
        // 16-bit wrap in mid-window, then restart without clearing
        load(8'h01, 8'hfe, 8'hff, 8'h00, 8'h00);
        run_for(8'h10, 3);
        rdchk("low0 m1", SFR_LOW_ZERO_ADDR, 8'h01);
        rdchk("high0 m1", SFR_HIGH_ZERO_ADDR, 8'h00);
        chk("flag0 set", 8'h01, {7'h00, overflow_flag_zero});
        vec(1'b1, 1'b0);
        chk("flag0 clr", 8'h00, {7'h00, overflow_flag_zero});
        run_for(8'h10, 1);
        rdchk("low0 rerun", SFR_LOW_ZERO_ADDR, 8'h02);
        // 13-bit wrap of timer 1; top low bits left alone
        load(8'h00, 8'h00, 8'h00, 8'hff, 8'hff);
        run_for(8'h40, 1);
        rdchk("low1 m0", SFR_LOW_ONE_ADDR, 8'he0);
        rdchk("high1 m0", SFR_HIGH_ONE_ADDR, 8'h00);
        chk("flag1 set", 8'h01, {7'h00, overflow_flag_one});
        vec(1'b0, 1'b1);
        chk("flag1 clr", 8'h00, {7'h00, overflow_flag_one});
        // Reload on the first count, plain count on the second
        load(8'h02, 8'hff, 8'h80, 8'h00, 8'h00);
        run_for(8'h10, 2);
        rdchk("low0 m2", SFR_LOW_ZERO_ADDR, 8'h81);
        rdchk("high0 m2", SFR_HIGH_ZERO_ADDR, 8'h80);
        chk("flag0 m2", 8'h01, {7'h00, overflow_flag_zero});
        vec(1'b1, 1'b0);
        // Split timer 0, timer 1 held
        load(8'h33, 8'h10, 8'hff, 8'h33, 8'h44);
        run_for(8'h50, 2);
        rdchk("low0 m3", SFR_LOW_ZERO_ADDR, 8'h12);
        rdchk("high0 m3", SFR_HIGH_ZERO_ADDR, 8'h01);
        rdchk("low1 m3", SFR_LOW_ONE_ADDR, 8'h33);
        rdchk("high1 m3", SFR_HIGH_ONE_ADDR, 8'h44);
        chk("flag1 m3", 8'h01, {7'h00, overflow_flag_one});
        chk("flag0 m3", 8'h00, {7'h00, overflow_flag_zero});
        vec(1'b0, 1'b1);
        // Both timers counting pin falls at the fastest legal rate
        load(8'h55, 8'h00, 8'h00, 8'h00, 8'h00);
        wr(SFR_RUN_FLAG_CTL_ADDR, 8'h50);
        fork
            i_src_zero.burst(3);
            i_src_one.burst(5);
        join
        repeat (40) @(posedge clk);
        wr(SFR_RUN_FLAG_CTL_ADDR, 8'h00);
        rdchk("low0 cnt", SFR_LOW_ZERO_ADDR, 8'h03);
        rdchk("low1 cnt", SFR_LOW_ONE_ADDR, 8'h05);
        // Latch bit clear: pin reads zero, falls ignored
        port3_latch = 8'hef;
        repeat (30) @(posedge clk);
        wr(SFR_RUN_FLAG_CTL_ADDR, 8'h10);
        i_src_zero.burst(2);
        repeat (40) @(posedge clk);
        wr(SFR_RUN_FLAG_CTL_ADDR, 8'h00);
        rdchk("low0 latch", SFR_LOW_ZERO_ADDR, 8'h03);
        port3_latch = 8'hff;
        // Gating, then ungated with the pin low and the low nibble set
        load(8'h09, 8'h00, 8'h00, 8'h00, 8'h00);
        gate_irq_pin_zero = 1'b0;
        run_for(8'h10, 2);
        rdchk("gate low", SFR_LOW_ZERO_ADDR, 8'h00);
        gate_irq_pin_zero = 1'b1;
        run_for(8'h10, 2);
        rdchk("gate high", SFR_LOW_ZERO_ADDR, 8'h02);
        wr(SFR_MODE_SEL_ADDR, 8'h01);
        gate_irq_pin_zero = 1'b0;
        run_for(8'h1f, 2);
        rdchk("no gate", SFR_LOW_ZERO_ADDR, 8'h04);
        rdchk("ctl nibble", SFR_RUN_FLAG_CTL_ADDR, 8'h0f);
        // Timer one gated through a cleared latch bit, then a set one
        load(8'h80, 8'h00, 8'h00, 8'h00, 8'h00);
        port3_latch = 8'hf7;
        run_for(8'h40, 2);
        rdchk("gate1 latch", SFR_LOW_ONE_ADDR, 8'h00);
        port3_latch = 8'hff;
        run_for(8'h40, 2);
        rdchk("gate1 high", SFR_LOW_ONE_ADDR, 8'h02);
        finish_test();
    end
endmodule
`default_nettype wire
